//--- core/wcr_wake_context.sv
`timescale 1ns/10ps
`default_nettype none
module wcr_wake_context
   import wcr_pkg::*;
(
   // clock and core reset
   input  wire logic                             core_clk_i,
   input  wire logic                             nrst_i,
   // reset and suspend pins, all active low
   input  wire logic                             cold_reset_in_n_i,
   input  wire logic                             bus_reset_in_n_i,
   input  wire logic                             suspend_n_i,
   // configuration and socket register access
   input  wire logic                             cfg_rd_i,
   input  wire logic                             cfg_wr_i,
   input  wire logic                             cfg_space_i,
   input  wire logic [wcr_pkg::WCR_ADDR_W-1:0]   cfg_addr_i,
   input  wire logic [wcr_pkg::WCR_BE_W-1:0]     cfg_be_i,
   input  wire logic [wcr_pkg::WCR_DATA_W-1:0]   cfg_wdata_i,
   output logic      [wcr_pkg::WCR_DATA_W-1:0]   cfg_rdata_o,
   output logic                                  cfg_ack_o,
   // hardware event sources, same clock domain
   input  wire logic                             card_wake_i,
   input  wire logic [wcr_pkg::WCR_GPE_W-1:0]    gpe_event_i,
   input  wire logic [wcr_pkg::WCR_SOCK_EVT_W-1:0]  socket_change_i,
   input  wire logic [wcr_pkg::WCR_SOCK_PRES_W-1:0] socket_state_i,
   // events and levels toward the system
   output logic                                  wake_event_o,
   output logic                                  gpe_event_o,
   output logic      [wcr_pkg::WCR_GPO_W-1:0]    gp_out_o,
   output logic                                  wake_enable_o,
   output logic                                  suspended_o
);

   import wcr_pkg::*;

   // settled pin levels
   logic [2:0]            pin_level;
   logic                  cold_act;
   logic                  bus_act;
   logic                  susp_act;

   // gated resets and access qualifiers
   logic                  cold_eff;
   logic                  bus_eff;
   logic                  wr_take;
   logic                  rd_take;

   // register words and their inputs
   logic [31:0]           word_q     [WCR_NUM_REGS];
   logic [31:0]           hw_in      [WCR_NUM_REGS];
   logic [WCR_NUM_REGS-1:0] hit;
   logic [31:0]           be_mask;
   logic                  pme_en;
   logic [31:0]           rd_mux;

   // read path and output flops
   logic [31:0]           rdata_reg;
   logic                  ack_reg;
   logic                  wake_reg;
   logic                  gpe_reg;
   logic [WCR_GPO_W-1:0]  gpo_reg;
   logic                  wken_reg;
   logic                  susp_reg;

   // pins pass the three-flop filter before any use
   wcr_pin_sync #(
      .WIDTH   (3),
      .RST_VAL (1'b1)
   ) u_pin_sync (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .pin_i      ({suspend_n_i, bus_reset_in_n_i, cold_reset_in_n_i}),
      .level_o    (pin_level)
   );

   // active-high views of the settled pins
   assign cold_act = ~pin_level[0];
   assign bus_act  = ~pin_level[1];
   assign susp_act = ~pin_level[2];

   // suspend masks both resets so contents survive a reset during suspend
   assign cold_eff = cold_act & ~susp_act;
   assign bus_eff  = bus_act & ~susp_act & ~cold_act;

   // no access is taken while suspended or while a reset is applied;
   // this models the gated bus clock without gating core_clk_i itself
   assign wr_take = cfg_wr_i & ~susp_act & ~cold_act & ~bus_act;
   assign rd_take = cfg_rd_i & ~susp_act & ~cold_act & ~bus_act;

   // registered wake enable, sampled before the bus reset acts
   assign pme_en = word_q[WCR_IDX_POWER_CONTROL_STATUS][WCR_PME_EN_BIT];

   // byte enables widened to a bit mask
   always_comb begin
      for (int i = 0; i < WCR_BE_W; i++) begin
         be_mask[i*8 +: 8] = {8{cfg_be_i[i]}};
      end
   end

   // word decode: space plus dword-aligned printed offset
   always_comb begin
      hit = '0;
      for (int k = 0; k < WCR_NUM_REGS; k++) begin
         if (cfg_space_i != WCR_TBL_SPACE[k]) begin
            hit[k] = 1'b0;
         end else if (cfg_addr_i[11:2] == WCR_TBL_OFF[k][11:2]) begin
            hit[k] = 1'b1;
         end else begin
            hit[k] = 1'b0;
         end
      end
   end

   // hardware inputs per word: set bits, or loaded bits where hwld marks them
   always_comb begin
      for (int k = 0; k < WCR_NUM_REGS; k++) begin
         hw_in[k] = 32'h0000_0000;
      end
      hw_in[WCR_IDX_POWER_CONTROL_STATUS][WCR_PME_STAT_BIT] = card_wake_i;
      hw_in[WCR_IDX_GPE][WCR_GPE_W-1:0] = gpe_event_i;
      hw_in[WCR_IDX_SOCK_EVT][WCR_SOCK_EVT_W-1:0] = socket_change_i;
      hw_in[WCR_IDX_SOCK_PRES][WCR_SOCK_PRES_W-1:0] = socket_state_i;
   end

   // one storage word per table entry, each with its own reset class masks
   genvar k;
   generate
      for (k = 0; k < WCR_NUM_REGS; k++) begin : gen_word
         logic [31:0] word_reg;
         logic [31:0] word_next;
         logic [31:0] keep_mask;
         logic [31:0] wr_bits;

         // bits a bus reset leaves alone: cold-only always,
         // context bits only while the wake enable was already set
         assign keep_mask = WCR_TBL_COLD[k]
                          | (pme_en ? WCR_TBL_CTX[k]
                                    : 32'h0000_0000);

         assign wr_bits = (wr_take && hit[k]) ? (be_mask & WCR_TBL_WMASK[k])
                                              : 32'h0000_0000;

         // write, write-one-clear, then hardware set last so a set wins
         always_comb begin
            word_next = word_reg;
            word_next = (word_next & ~(wr_bits & ~WCR_TBL_W1C[k]))
                      | (cfg_wdata_i & wr_bits & ~WCR_TBL_W1C[k]);
            word_next = word_next & ~(cfg_wdata_i & wr_bits & WCR_TBL_W1C[k]);
            word_next = (word_next & ~WCR_TBL_HWLD[k]) | (hw_in[k] & WCR_TBL_HWLD[k]);
            word_next = word_next | (hw_in[k] & ~WCR_TBL_HWLD[k]);
         end

         // cold reset beats bus reset; neither acts during suspend
         always_ff @(posedge core_clk_i) begin
            if (!nrst_i) begin
               word_reg <= WCR_RST_VAL;
            end else if (cold_eff) begin
               word_reg <= WCR_RST_VAL;
            end else if (bus_eff) begin
               word_reg <= word_reg & keep_mask;
            end else begin
               word_reg <= word_next;
            end
         end

         assign word_q[k] = word_reg;
      end
   endgenerate

   // read mux; an unmapped word answers with zero
   always_comb begin
      rd_mux = WCR_RD_UNMAPPED;
      for (int i = 0; i < WCR_NUM_REGS; i++) begin
         if (hit[i]) begin
            rd_mux = word_q[i];
         end
      end
   end

   // read data registered so the port sees a clean value
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rdata_reg <= WCR_RD_UNMAPPED;
      end else if (rd_take) begin
         rdata_reg <= rd_mux;
      end
   end

   // one-cycle acknowledge for every taken access, mapped or not
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= rd_take | wr_take;
      end
   end

   // wake event: status bit with its own enable
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= word_q[WCR_IDX_POWER_CONTROL_STATUS][WCR_PME_STAT_BIT] & pme_en;
      end
   end

   // driver event: any pending status whose enable is set
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         gpe_reg <= 1'b0;
      end else begin
         gpe_reg <= |(word_q[WCR_IDX_GPE][WCR_GPE_W-1:0]
                    & word_q[WCR_IDX_GPE][WCR_GPE_EN_LSB +: WCR_GPE_W]);
      end
   end

   // general outputs stay driven during suspend, they live in the word
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         gpo_reg <= '0;
      end else begin
         gpo_reg <= word_q[WCR_IDX_GPIO][WCR_GPO_LSB +: WCR_GPO_W];
      end
   end

   // wake enable mirrored out for system power logic
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wken_reg <= 1'b0;
      end else begin
         wken_reg <= pme_en;
      end
   end

   // suspend status, from the settled pin
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         susp_reg <= 1'b0;
      end else begin
         susp_reg <= susp_act;
      end
   end

   // outputs straight from flops
   assign cfg_rdata_o   = rdata_reg;
   assign cfg_ack_o     = ack_reg;
   assign wake_event_o  = wake_reg;
   assign gpe_event_o   = gpe_reg;
   assign gp_out_o      = gpo_reg;
   assign wake_enable_o = wken_reg;
   assign suspended_o   = susp_reg;

endmodule // wcr_wake_context
`default_nettype wire

//--- inc/wcr_pkg.sv
`default_nettype none
package wcr_pkg;

   // access port geometry
   localparam int          WCR_ADDR_W     = 12;
   localparam int          WCR_DATA_W     = 32;
   localparam int          WCR_BE_W       = 4;
   localparam int          WCR_NUM_REGS   = 20;
   localparam int          WCR_IDX_W      = 5;

   // address spaces seen on the access port
   localparam logic        WCR_SPACE_CFG  = 1'b0;
   localparam logic        WCR_SPACE_SOCK = 1'b1;

   // printed byte offsets, configuration space
   localparam logic [11:0] WCR_OFF_BRIDGE_CTL           = 12'h03E;
   localparam logic [11:0] WCR_OFF_SUBSYS_VENDOR        = 12'h040;
   localparam logic [11:0] WCR_OFF_LEGACY_BASE          = 12'h044;
   localparam logic [11:0] WCR_OFF_SYS_CTL              = 12'h080;
   localparam logic [11:0] WCR_OFF_MFUNC_ROUTE          = 12'h08C;
   localparam logic [11:0] WCR_OFF_RETRY_STAT           = 12'h090;
   localparam logic [11:0] WCR_OFF_SOCK_XFER0           = 12'h094;
   localparam logic [11:0] WCR_OFF_SOCK_XFER1           = 12'h098;
   localparam logic [11:0] WCR_OFF_POWER_CAPABILITIES   = 12'h0A2;
   localparam logic [11:0] WCR_OFF_POWER_CONTROL_STATUS = 12'h0A4;
   localparam logic [11:0] WCR_OFF_GP_EVENT_STATUS      = 12'h0A8;
   localparam logic [11:0] WCR_OFF_GP_EVENT_ENABLE      = 12'h0AA;
   localparam logic [11:0] WCR_OFF_GP_INOUT             = 12'h0AC;
   localparam logic [11:0] WCR_OFF_SERIAL_BUS           = 12'h0B0;
   // printed byte offsets, socket space
   localparam logic [11:0] WCR_OFF_SOCK_EVENT           = 12'h000;
   localparam logic [11:0] WCR_OFF_SOCK_MASK            = 12'h004;
   localparam logic [11:0] WCR_OFF_SOCK_PRESENT         = 12'h008;
   localparam logic [11:0] WCR_OFF_SOCK_CTL             = 12'h010;
   localparam logic [11:0] WCR_OFF_LEGACY_ID_PWR        = 12'h800;
   localparam logic [11:0] WCR_OFF_LEGACY_CSC           = 12'h804;
   localparam logic [11:0] WCR_OFF_LEGACY_GLOBAL        = 12'h81E;

   // word indices the logic reaches directly
   localparam int          WCR_IDX_POWER_CONTROL_STATUS      = 9;
   localparam int          WCR_IDX_GPE        = 10;
   localparam int          WCR_IDX_GPIO       = 11;
   localparam int          WCR_IDX_SOCK_EVT   = 13;
   localparam int          WCR_IDX_SOCK_PRES  = 15;

   // field positions
   localparam int          WCR_PME_EN_BIT     = 8;
   localparam int          WCR_PME_STAT_BIT   = 15;
   localparam int          WCR_GPE_EN_LSB     = 16;
   localparam int          WCR_GPO_LSB        = 16;
   localparam int          WCR_GPO_W          = 5;
   localparam int          WCR_GPE_W          = 16;
   localparam int          WCR_SOCK_EVT_W     = 4;
   localparam int          WCR_SOCK_PRES_W    = 14;

   // reset values
   localparam logic [31:0] WCR_RST_VAL        = 32'h0000_0000;
   localparam logic [31:0] WCR_RD_UNMAPPED    = 32'h0000_0000;

   // per-word table: space, printed offset, bus-reset survivors when wake enabled,
   // cold-only bits, writable bits, write-one-to-clear bits, hardware-loaded bits
   localparam logic WCR_TBL_SPACE [WCR_NUM_REGS] = '{
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   localparam logic [11:0] WCR_TBL_OFF [WCR_NUM_REGS] = '{
      WCR_OFF_BRIDGE_CTL, WCR_OFF_SUBSYS_VENDOR, WCR_OFF_LEGACY_BASE, WCR_OFF_SYS_CTL,
      WCR_OFF_MFUNC_ROUTE, WCR_OFF_RETRY_STAT, WCR_OFF_SOCK_XFER0, WCR_OFF_SOCK_XFER1,
      WCR_OFF_POWER_CAPABILITIES, WCR_OFF_POWER_CONTROL_STATUS, WCR_OFF_GP_EVENT_STATUS,
      WCR_OFF_GP_INOUT, WCR_OFF_SERIAL_BUS, WCR_OFF_SOCK_EVENT, WCR_OFF_SOCK_MASK,
      WCR_OFF_SOCK_PRESENT, WCR_OFF_SOCK_CTL, WCR_OFF_LEGACY_ID_PWR, WCR_OFF_LEGACY_CSC,
      WCR_OFF_LEGACY_GLOBAL};
   localparam logic [31:0] WCR_TBL_CTX [WCR_NUM_REGS] = '{
      32'h0040_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h8000_0000, 32'h0000_8100,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_000F, 32'h0000_000F,
      32'h0000_3CBF, 32'h0000_0077, 32'h601B_0000, 32'h0000_0F00, 32'h0000_0000};
   localparam logic [31:0] WCR_TBL_COLD [WCR_NUM_REGS] = '{
      32'h0000_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hCDFF_C0FF, 32'h0FFF_FFFF,
      32'hFFEF_E7CA, 32'h0000_0003, 32'h0000_FFF7, 32'h0000_0000, 32'h0000_0000,
      32'h891F_0000, 32'h001F_0000, 32'h84FF_FFFF, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_000F, 32'h000F_0000};
   localparam logic [31:0] WCR_TBL_WMASK [WCR_NUM_REGS] = '{
      32'hFFFF_00FF, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0000_8103,
      32'hFFFF_FFFF, 32'h001F_0000, 32'hFFFF_FFFF, 32'h0000_000F, 32'h0000_000F,
      32'h0000_0000, 32'h0000_0077, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF};
   localparam logic [31:0] WCR_TBL_W1C [WCR_NUM_REGS] = '{
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_8000,
      32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_000F, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   localparam logic [31:0] WCR_TBL_HWLD [WCR_NUM_REGS] = '{
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_3CBF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

endpackage
`default_nettype wire

//--- core/wcr_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-flop pin synchroniser; the settled value moves only when stages two and three agree
module wcr_pin_sync #(
   parameter int         WIDTH   = 1,
   parameter logic [0:0] RST_VAL = 1'b1
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             nrst_i,
   // raw pins and settled levels
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync2_reg;
   logic [WIDTH-1:0] sync3_reg;

   // capture chain; meta_reg feeds only sync2_reg
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         meta_reg  <= {WIDTH{RST_VAL}};
         sync2_reg <= {WIDTH{RST_VAL}};
         sync3_reg <= {WIDTH{RST_VAL}};
      end else begin
         meta_reg  <= pin_i;
         sync2_reg <= meta_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // per-bit agreement filter: a one-cycle glitch never reaches level_o
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : gen_bit
         always_ff @(posedge core_clk_i) begin
            if (!nrst_i) begin
               level_o[b] <= RST_VAL;
            end else if (sync2_reg[b] == sync3_reg[b]) begin
               level_o[b] <= sync3_reg[b];
            end
         end
      end
   endgenerate

endmodule // wcr_pin_sync
`default_nettype wire

//--- tb/wcr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// system reset and power logic: bench requests become registered low-active pins
module wcr_host_model (
   // clock
   input  wire logic core_clk_i,
   // requests from the bench
   input  wire logic cold_req_i,
   input  wire logic bus_req_i,
   input  wire logic susp_req_i,
   // pins toward the bridge
   output logic      cold_reset_in_n_o,
   output logic      bus_reset_in_n_o,
   output logic      suspend_n_o
);
   // pins start inactive, so no reset fires before the core leaves its own
   initial begin
      cold_reset_in_n_o = 1'b1;
      bus_reset_in_n_o = 1'b1;
      suspend_n_o = 1'b1;
   end
   // cold only when asked for (first boot); bus reset marks the off-to-on move
   always @(posedge core_clk_i) begin
      cold_reset_in_n_o <= !cold_req_i;
      bus_reset_in_n_o <= !bus_req_i;
      suspend_n_o <= !susp_req_i;
   end
endmodule // wcr_host_model
`default_nettype wire

//--- tb/wcr_wake_context_checker.sv
`timescale 1ns/10ps
`default_nettype none
// pin-level relations; windows of 6 to 8 cycles cover the three-flop pin filters
module wcr_wake_context_checker
   import wcr_pkg::*;
(
   // clock and reset
   input wire logic                          core_clk_i,
   input wire logic                          nrst_i,
   // reset and suspend pins
   input wire logic                          cold_reset_in_n_i,
   input wire logic                          bus_reset_in_n_i,
   input wire logic                          suspend_n_i,
   // access port
   input wire logic                          cfg_rd_i,
   input wire logic                          cfg_wr_i,
   input wire logic                          cfg_ack_o,
   // events and levels
   input wire logic                          card_wake_i,
   input wire logic [wcr_pkg::WCR_GPE_W-1:0] gpe_event_i,
   input wire logic                          wake_event_o,
   input wire logic                          gpe_event_o,
   input wire logic [wcr_pkg::WCR_GPO_W-1:0] gp_out_o,
   input wire logic                          wake_enable_o,
   input wire logic                          suspended_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_cold_clr;
      (!cold_reset_in_n_i && suspend_n_i)[*8] |=>
         !wake_enable_o && !wake_event_o && !gpe_event_o && gp_out_o == '0;
   endproperty
   a_cold_clr: assert property (p_cold_clr) else $error("cold reset left state set");
   property p_bus_keep;
      wake_enable_o && bus_reset_in_n_i ##1
      (!bus_reset_in_n_i && cold_reset_in_n_i && suspend_n_i && !cfg_wr_i)[*8] |=> wake_enable_o;
   endproperty
   a_bus_keep: assert property (p_bus_keep) else $error("wake enable lost");
   property p_gpo_keep;
      (!bus_reset_in_n_i && cold_reset_in_n_i)[*8] |-> $stable(gp_out_o);
   endproperty
   a_gpo_keep: assert property (p_gpo_keep) else $error("bus reset moved outputs");
   property p_susp_keep;
      (!suspend_n_i)[*8] |-> $stable(wake_enable_o) && $stable(gp_out_o);
   endproperty
   a_susp_keep: assert property (p_susp_keep) else $error("state moved in suspend");
   property p_susp_drop;
      (!suspend_n_i)[*6] ##0 (cfg_rd_i || cfg_wr_i) |=> !cfg_ack_o;
   endproperty
   a_susp_drop: assert property (p_susp_drop) else $error("access taken in suspend");
   property p_susp_flag;
      (!suspend_n_i)[*7] |-> suspended_o;
   endproperty
   a_susp_flag: assert property (p_susp_flag) else $error("suspend not seen");
   property p_wake_en;
      $rose(wake_event_o) |-> $past(card_wake_i, 2) || $past(cfg_wr_i, 2);
   endproperty
   a_wake_en: assert property (p_wake_en) else $error("wake event without cause");
   property p_card_wake;
      card_wake_i && wake_enable_o && !cfg_wr_i && !$past(cfg_wr_i) && bus_reset_in_n_i
      && cold_reset_in_n_i |-> ##2 wake_event_o;
   endproperty
   a_card_wake: assert property (p_card_wake) else $error("wake event missing");
   property p_gpe_src;
      $rose(gpe_event_o) |-> $past(gpe_event_i, 2) != '0 || $past(cfg_wr_i, 2);
   endproperty
   a_gpe_src: assert property (p_gpe_src) else $error("event without cause");

   c_cold: cover property ((!cold_reset_in_n_i)[*8]);
   c_gpe: cover property ($rose(gpe_event_o));
   c_wake: cover property ($rose(wake_event_o));
   c_susp: cover property ($rose(suspended_o));
endmodule // wcr_wake_context_checker

bind wcr_wake_context wcr_wake_context_checker u_chk (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cold_reset_in_n_i(cold_reset_in_n_i),
   .bus_reset_in_n_i(bus_reset_in_n_i), .suspend_n_i(suspend_n_i), .cfg_rd_i(cfg_rd_i),
   .cfg_wr_i(cfg_wr_i), .cfg_ack_o(cfg_ack_o), .card_wake_i(card_wake_i),
   .gpe_event_i(gpe_event_i), .wake_event_o(wake_event_o), .gpe_event_o(gpe_event_o),
   .gp_out_o(gp_out_o), .wake_enable_o(wake_enable_o), .suspended_o(suspended_o));
`default_nettype wire

//--- tb/wake_context_reset_domains_bench.sv
`timescale 1ns/10ps
`default_nettype none
// random register images pushed through cold, bus and suspend resets
module wake_context_reset_domains_bench;
   import wcr_pkg::*;
   // clock, reset, pin requests
   logic                  clk = 1'b0;
   logic                  nrst = 1'b0;
   logic                  cold_req = 1'b0, bus_req = 1'b0, susp_req = 1'b0;
   logic                  cold_n, bus_n, susp_n;
   // access port, events, levels
   logic                  rd = 1'b0, wr = 1'b0, sp = 1'b0;
   logic [WCR_ADDR_W-1:0] ad = '0;
   logic [WCR_BE_W-1:0]   be = '0;
   logic [WCR_DATA_W-1:0] wd = '0, rdat;
   logic                  ack, wev, gev, wen, susp_o, cwake = 1'b0;
   logic [WCR_GPO_W-1:0]  gpo;
   logic [WCR_GPE_W-1:0]  gin = '0;
   logic [3:0]            schg = '0;
   logic [13:0]           sst = '0;
   // expected words and counters
   logic [31:0]           exp_w [WCR_NUM_REGS];
   int                    seed = 32'h2eb635c8;
   int                    mismatches = 0;
   int                    compares = 0;

   // 200 MHz
   always #2.5 clk = ~clk;

   wcr_wake_context u_dut (
      .core_clk_i(clk), .nrst_i(nrst), .cold_reset_in_n_i(cold_n), .bus_reset_in_n_i(bus_n),
      .suspend_n_i(susp_n), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_space_i(sp), .cfg_addr_i(ad),
      .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_ack_o(ack),
      .card_wake_i(cwake), .gpe_event_i(gin), .socket_change_i(schg), .socket_state_i(sst),
      .wake_event_o(wev), .gpe_event_o(gev), .gp_out_o(gpo), .wake_enable_o(wen),
      .suspended_o(susp_o));
   wcr_host_model u_host (
      .core_clk_i(clk), .cold_req_i(cold_req), .bus_req_i(bus_req), .susp_req_i(susp_req),
      .cold_reset_in_n_o(cold_n), .bus_reset_in_n_o(bus_n), .suspend_n_o(susp_n));

   // verdict and end of run
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // one access; a refused one is watched 4 cycles for a stray ack
   task automatic acc(input logic w, input logic s, input logic [11:0] a, input logic [3:0] b,
                      input logic [31:0] d, input logic want, output logic [31:0] q);
      logic got;
      got = 1'b0;
      q = '0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      sp <= s;
      ad <= {a[11:2], 2'b00};
      be <= b;
      wd <= d;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      for (int n = 0; n < 4 && !got; n++) begin
         @(negedge clk);
         got = (ack === 1'b1);
         q = rdat;
      end
      chk(got, want);
      if (want && !got) stop_test();
   endtask
   // expected word after a write: byte lanes, writable and write-one-to-clear bits
   function automatic logic [31:0] after_wr(input int i, input logic [31:0] d,
                                            input logic [3:0] b);
      logic [31:0] m, p;
      m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & WCR_TBL_WMASK[i];
      p = m & ~WCR_TBL_W1C[i];
      return ((exp_w[i] & ~p) | (d & p)) & ~(d & m & WCR_TBL_W1C[i]);
   endfunction
   // survivors of a reset; present-state bits reload from the socket afterwards
   task automatic keep(input logic cold, input logic wake_event);
      for (int i = 0; i < WCR_NUM_REGS; i++) begin
         exp_w[i] &= cold ? 32'h0 : WCR_TBL_COLD[i] | (wake_event ? WCR_TBL_CTX[i] : 32'h0);
      end
      exp_w[WCR_IDX_SOCK_PRES] = {18'h0, sst};
   endtask
   task automatic wr_all(input logic wake_event);
      logic [31:0] d, q;
      logic [3:0]  b;
      for (int i = 0; i < WCR_NUM_REGS; i++) begin
         d = $random(seed);
         b = 4'($random(seed));
         if (i == WCR_IDX_POWER_CONTROL_STATUS) begin
            d[WCR_PME_EN_BIT] = wake_event;
            b[1] = 1'b1;
         end
         exp_w[i] = after_wr(i, d, b);
         acc(1'b1, WCR_TBL_SPACE[i], WCR_TBL_OFF[i], b, d, 1'b1, q);
      end
   endtask
   task automatic rd_all();
      logic [31:0] q;
      for (int i = 0; i < WCR_NUM_REGS; i++) begin
         acc(1'b0, WCR_TBL_SPACE[i], WCR_TBL_OFF[i], 4'h0, 32'h0, 1'b1, q);
         chk(q, exp_w[i]);
      end
      chk(gpo, exp_w[WCR_IDX_GPIO][20:16]);
      chk(wen, exp_w[WCR_IDX_POWER_CONTROL_STATUS][WCR_PME_EN_BIT]);
   endtask
   // reset pins held 10 cycles, then 8 for the filters to let go
   task automatic rst_pulse(input logic c, input logic b);
      @(posedge clk);
      cold_req <= c;
      bus_req <= b;
      repeat (10) @(posedge clk);
      cold_req <= 1'b0;
      bus_req <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   // main sequence
   initial begin
      int          j;
      logic [31:0] q;
      sst = 14'($random(seed));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      keep(1'b1, 1'b0);
      rd_all();
      acc(1'b1, 1'b0, 12'h0C0, 4'hF, 32'hFFFF_FFFF, 1'b1, q);
      acc(1'b0, 1'b0, 12'h0C0, 4'h0, 32'h0, 1'b1, q);
      chk(q, WCR_RD_UNMAPPED);
      $display("test map done");
      wr_all(1'b1);
      rd_all();
      rst_pulse(1'b0, 1'b1);
      keep(1'b0, 1'b1);
      rd_all();
      $display("test bus_keep done");
      wr_all(1'b0);
      rst_pulse(1'b0, 1'b1);
      keep(1'b0, 1'b0);
      rd_all();
      $display("test bus_clear done");
      wr_all(1'b1);
      @(posedge clk);
      susp_req <= 1'b1;
      repeat (8) @(posedge clk);
      chk(susp_o, 1'b1);
      rst_pulse(1'b1, 1'b1);
      acc(1'b1, 1'b0, WCR_OFF_GP_INOUT, 4'hF, 32'hFFFF_FFFF, 1'b0, q);
      @(posedge clk);
      susp_req <= 1'b0;
      repeat (8) @(posedge clk);
      rd_all();
      $display("test suspend done");
      for (int k = 0; k < 4; k++) begin
         j = {$random(seed)} % 16;
         acc(1'b1, 1'b0, WCR_OFF_GP_EVENT_STATUS, 4'hC, {15'h0, k[0], 16'h0} << j, 1'b1, q);
         @(posedge clk);
         gin <= 16'h1 << j;
         @(posedge clk);
         gin <= '0;
         repeat (3) @(negedge clk);
         chk(gev, k[0]);
         acc(1'b0, 1'b0, WCR_OFF_GP_EVENT_STATUS, 4'h0, 32'h0, 1'b1, q);
         chk(q[15:0], 16'h1 << j);
         acc(1'b1, 1'b0, WCR_OFF_GP_EVENT_STATUS, 4'h3, 32'h1 << j, 1'b1, q);
         repeat (3) @(negedge clk);
         chk(gev, 1'b0);
      end
      acc(1'b1, 1'b0, WCR_OFF_POWER_CONTROL_STATUS, 4'h3, 32'h100, 1'b1, q);
      @(posedge clk);
      cwake <= 1'b1;
      @(posedge clk);
      cwake <= 1'b0;
      schg <= 4'h5;
      @(posedge clk);
      schg <= '0;
      rst_pulse(1'b0, 1'b1);
      chk(wev, 1'b1);
      acc(1'b0, 1'b0, WCR_OFF_POWER_CONTROL_STATUS, 4'h0, 32'h0, 1'b1, q);
      chk(q & 32'h8100, 32'h8100);
      acc(1'b0, 1'b1, WCR_OFF_SOCK_EVENT, 4'h0, 32'h0, 1'b1, q);
      chk(q[3:0], 4'h5);
      acc(1'b1, 1'b0, WCR_OFF_POWER_CONTROL_STATUS, 4'h3, 32'h8100, 1'b1, q);
      repeat (3) @(negedge clk);
      chk(wev, 1'b0);
      $display("test events done");
      wr_all(1'b1);
      rst_pulse(1'b1, 1'b1);
      keep(1'b1, 1'b1);
      rd_all();
      $display("test cold done");
      stop_test();
   end
endmodule // wake_context_reset_domains_bench
`default_nettype wire
